// ===== hw/trig_defs.svh
// Timing constants and reset values of the time-qualified trigger
`ifndef TRIG_DEFS_SVH
`define TRIG_DEFS_SVH

`define CLK_PERIOD_PS        20000
`define WIN_WIDTH_RST_PS     5000
`define WIN_TOL_RST_PS       0
`define STUCK_DUR_RST_PS     100000
`define GAP_WIDTH_RST_PS     5000
`define GAP_TOL_RST_PS       0
// Least times round up to whole cycles; a zero time stays zero
`define WIN_WIDTH_RST_CYC \
  ((`WIN_WIDTH_RST_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WIN_TOL_RST_CYC      (`WIN_TOL_RST_PS / `CLK_PERIOD_PS)
`define STUCK_DUR_RST_CYC \
  ((`STUCK_DUR_RST_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define GAP_WIDTH_RST_CYC \
  ((`GAP_WIDTH_RST_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define GAP_TOL_RST_CYC      (`GAP_TOL_RST_PS / `CLK_PERIOD_PS)
// 10000 s at 20 ns needs 39 bits
`define CNT_WIDTH            40
`define CHAN_COUNT           8

`endif

// ===== hw/trig_pkg.sv
// Mode and option types of the time-qualified trigger
package trig_pkg;
  typedef enum logic [1:0] {KIND_WINDOW, KIND_TIMEOUT, KIND_INTERVAL}
    trig_kind_t;
  typedef enum logic [1:0] {WIN_ENTER, WIN_EXIT, WIN_STAY_IN, WIN_STAY_OUT}
    win_option_t;
  typedef enum logic [1:0] {DUR_WITHIN, DUR_OUTSIDE, DUR_SHORTER, DUR_LONGER}
    dur_cond_t;
  typedef enum logic [1:0] {STUCK_HIGH, STUCK_LOW, STUCK_ANY_POLARITY}
    stuck_pol_t;
  typedef enum logic [1:0] {GAP_WITHIN, GAP_OUTSIDE, GAP_SHORTER, GAP_LONGER}
    gap_cmp_t;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_ANY_POLARITY}
    gap_pol_t;
endpackage

// ===== hw/time_qual_trigger.sv
// Window, timeout and interval trigger qualified by duration
// Summary of operation
// - Duration condition applies only to stay-inside or stay-outside options
// - Within: duration between width-delta and width+delta; default
// - Outside: duration below width-delta or above width+delta
// - Shorter: window state ends before width elapses
// - Width is the centre of the plus/minus delta range
// - Width is maximum for shorter, minimum for longer
// - Timeout qualifies on high, low or any_polarity; high default
// - Fire when timeout level holds for programmed duration
// - Interval delta is tolerance band around width, default zero
// - Interval within: gap inside width plus or minus delta
// - Interval outside: gap outside the band; default
// - Interval shorter: gap less than width
// - Interval longer: gap more than width
// - Gap measured between rising, falling or any edges; rising default
// - Interval width is nominal gap, default five nanoseconds
// - Window delta is symmetric tolerance, default zero
// - Window option: enter, exit, stay inside, stay outside; enter default
// - Window limits come from comparators of channel one to eight
`timescale 1ns/10ps
`include "trig_defs.svh"
module time_qual_trigger
  import trig_pkg::*;
#(
  parameter int NCH = `CHAN_COUNT,
  parameter int CW  = `CNT_WIDTH
) (
  input  wire              i_clk,
  input  wire              i_rst_n,
  input  wire [NCH-1:0]    i_above_upper,
  input  wire [NCH-1:0]    i_below_lower,
  input  wire [NCH-1:0]    i_above_level,
  input  wire              i_cfg_load,
  input  wire [$clog2(NCH)-1:0] i_src_chan,
  input  trig_kind_t       i_trig_kind,
  input  win_option_t      i_window_compare_option,
  input  dur_cond_t        i_window_duration_condition,
  input  wire [CW-1:0]     i_window_nominal_duration,
  input  wire [CW-1:0]     i_window_duration_tolerance,
  input  stuck_pol_t       i_stuck_level_polarity,
  input  wire [CW-1:0]     i_stuck_level_duration,
  input  gap_cmp_t         i_edge_gap_compare_option,
  input  gap_pol_t         i_edge_gap_polarity,
  input  wire [CW-1:0]     i_edge_gap_nominal,
  input  wire [CW-1:0]     i_edge_gap_tolerance,
  output logic             o_trigger,
  output logic             o_gap_armed
);
  localparam int CHW = $clog2(NCH);

  typedef struct packed {
    logic [3*NCH-1:0] sync1;
    logic [3*NCH-1:0] sync2;
    logic [2:0]       prev;
    logic [CHW-1:0]   chan;
    trig_kind_t       kind;
    win_option_t      win_opt;
    dur_cond_t        win_cond;
    logic [CW-1:0]    win_w;
    logic [CW-1:0]    win_tol;
    stuck_pol_t       to_pol;
    logic [CW-1:0]    to_dur;
    gap_cmp_t         gap_cmp;
    gap_pol_t         gap_pol;
    logic [CW-1:0]    gap_w;
    logic [CW-1:0]    gap_tol;
    logic [CW-1:0]    wcnt;
    logic [CW-1:0]    tcnt;
    logic [CW-1:0]    gcnt;
    logic             armed;
    logic             trig;
  } state_t;

  localparam state_t RST_STATE = '{
    sync1: '0, sync2: '0, prev: '0, chan: '0,
    kind: KIND_WINDOW, win_opt: WIN_ENTER, win_cond: DUR_WITHIN,
    win_w: CW'(`WIN_WIDTH_RST_CYC), win_tol: CW'(`WIN_TOL_RST_CYC),
    to_pol: STUCK_HIGH, to_dur: CW'(`STUCK_DUR_RST_CYC),
    gap_cmp: GAP_OUTSIDE, gap_pol: EDGE_RISE,
    gap_w: CW'(`GAP_WIDTH_RST_CYC), gap_tol: CW'(`GAP_TOL_RST_CYC),
    wcnt: '0, tcnt: '0, gcnt: '0, armed: 1'b0, trig: 1'b0};

  state_t s_q;
  state_t s_d;

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (&v) ? v : v + CW'(1);
  endfunction

  // Selected channel: upper, lower, level comparator after sync
  logic [2:0]    cur;
  logic          in_now;
  logic          in_prev;
  logic          wq_now;
  logic          wq_prev;
  logic          win_end;
  logic          win_lo_ok;
  logic          win_hi_ok;
  logic          win_fire;
  logic          lvl;
  logic          to_cond;
  logic [CW-1:0] tcnt_n;
  logic          to_fire;
  logic          gap_edge;
  logic          gap_lo_ok;
  logic          gap_hi_ok;
  logic          gap_fire;
  logic          fire;

  assign cur = {s_q.sync2[2*NCH + int'(s_q.chan)],
                s_q.sync2[NCH + int'(s_q.chan)],
                s_q.sync2[int'(s_q.chan)]};
  assign in_now  = !cur[2] && !cur[1];
  assign in_prev = !s_q.prev[2] && !s_q.prev[1];
  assign wq_now  = (s_q.win_opt == WIN_STAY_IN) ? in_now : !in_now;
  assign wq_prev = (s_q.win_opt == WIN_STAY_IN) ? in_prev : !in_prev;
  assign win_end = wq_prev && !wq_now;
  // Width is the centre of the band; sums kept one bit wider
  assign win_lo_ok = ({1'b0, s_q.wcnt} + {1'b0, s_q.win_tol})
                     >= {1'b0, s_q.win_w};
  assign win_hi_ok = {1'b0, s_q.wcnt}
                     <= ({1'b0, s_q.win_w} + {1'b0, s_q.win_tol});

  always_comb
  begin
    win_fire = 1'b0;
    case (s_q.win_opt)
      WIN_ENTER: win_fire = in_now && !in_prev;
      WIN_EXIT:  win_fire = !in_now && in_prev;
      default:
      begin
        case (s_q.win_cond)
          DUR_WITHIN:  win_fire = win_end && win_lo_ok && win_hi_ok;
          DUR_OUTSIDE: win_fire = win_end && !(win_lo_ok && win_hi_ok);
          DUR_SHORTER: win_fire = win_end && (s_q.wcnt < s_q.win_w);
          DUR_LONGER:  win_fire = wq_now && (s_q.wcnt == s_q.win_w);
          default:     win_fire = 1'b0;
        endcase
      end
    endcase
  end

  assign lvl = cur[0];
  always_comb
  begin
    case (s_q.to_pol)
      STUCK_HIGH: to_cond = lvl;
      STUCK_LOW:  to_cond = !lvl;
      default:    to_cond = 1'b1;
    endcase
  end
  // A level change restarts the run in any_polarity-polarity mode
  assign tcnt_n = !to_cond ? '0 :
                  (lvl == s_q.prev[0]) ? sat_inc(s_q.tcnt) : CW'(1);
  assign to_fire = to_cond && (tcnt_n == s_q.to_dur)
                   && (s_q.tcnt != s_q.to_dur);

  always_comb
  begin
    case (s_q.gap_pol)
      EDGE_RISE: gap_edge = lvl && !s_q.prev[0];
      EDGE_FALL: gap_edge = !lvl && s_q.prev[0];
      default:   gap_edge = lvl != s_q.prev[0];
    endcase
  end
  assign gap_lo_ok = ({1'b0, s_q.gcnt} + {1'b0, s_q.gap_tol})
                     >= {1'b0, s_q.gap_w};
  assign gap_hi_ok = {1'b0, s_q.gcnt}
                     <= ({1'b0, s_q.gap_w} + {1'b0, s_q.gap_tol});

  always_comb
  begin
    gap_fire = 1'b0;
    if (gap_edge && s_q.armed)
    begin
      case (s_q.gap_cmp)
        GAP_WITHIN:  gap_fire = gap_lo_ok && gap_hi_ok;
        GAP_OUTSIDE: gap_fire = !(gap_lo_ok && gap_hi_ok);
        GAP_SHORTER: gap_fire = s_q.gcnt < s_q.gap_w;
        GAP_LONGER:  gap_fire = s_q.gcnt > s_q.gap_w;
        default:     gap_fire = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    case (s_q.kind)
      KIND_WINDOW:   fire = win_fire;
      KIND_TIMEOUT:  fire = to_fire;
      KIND_INTERVAL: fire = gap_fire;
      default:       fire = 1'b0;
    endcase
  end

  always_comb
  begin
    s_d       = s_q;
    s_d.sync1 = {i_above_upper, i_below_lower, i_above_level};
    s_d.sync2 = s_q.sync1;
    s_d.prev  = cur;
    s_d.wcnt  = wq_now ? sat_inc(s_q.wcnt) : '0;
    s_d.tcnt  = tcnt_n;
    s_d.gcnt  = gap_edge ? CW'(1) : sat_inc(s_q.gcnt);
    s_d.armed = s_q.armed || gap_edge;
    s_d.trig  = fire;
    if (i_cfg_load)
    begin
      s_d.chan     = i_src_chan;
      s_d.kind     = i_trig_kind;
      s_d.win_opt  = i_window_compare_option;
      s_d.win_cond = i_window_duration_condition;
      s_d.win_w    = i_window_nominal_duration;
      s_d.win_tol  = i_window_duration_tolerance;
      s_d.to_pol   = i_stuck_level_polarity;
      s_d.to_dur   = i_stuck_level_duration;
      s_d.gap_cmp  = i_edge_gap_compare_option;
      s_d.gap_pol  = i_edge_gap_polarity;
      s_d.gap_w    = i_edge_gap_nominal;
      s_d.gap_tol  = i_edge_gap_tolerance;
      // New settings restart every measurement
      s_d.prev  = '0;
      s_d.wcnt  = '0;
      s_d.tcnt  = '0;
      s_d.gcnt  = '0;
      s_d.armed = 1'b0;
      s_d.trig  = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      s_q <= RST_STATE;
    else
      s_q <= s_d;
  end

  assign o_trigger   = s_q.trig;
  assign o_gap_armed = s_q.armed;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic loaded_q;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      loaded_q <= 1'b0;
    else if (i_cfg_load)
      loaded_q <= 1'b1;
  end

  reset_defaults_a: assert property (!loaded_q |-> s_q.win_cond == DUR_WITHIN
    && s_q.win_opt == WIN_ENTER && s_q.to_pol == STUCK_HIGH
    && s_q.gap_cmp == GAP_OUTSIDE && s_q.gap_pol == EDGE_RISE
    && s_q.win_tol == '0 && s_q.gap_tol == '0)
    else $error("Settings left defaults before any load");
  enter_edge_a: assert property (s_q.kind == KIND_WINDOW
    && s_q.win_opt == WIN_ENTER && in_now && !in_prev && !i_cfg_load
    |=> o_trigger)
    else $error("Window entry did not trigger");
  edge_mode_a: assert property (s_q.kind == KIND_WINDOW
    && s_q.win_opt inside {WIN_ENTER, WIN_EXIT} && in_now == in_prev
    |=> !o_trigger)
    else $error("Enter or exit fired without a crossing");
  win_within_a: assert property (s_q.kind == KIND_WINDOW
    && s_q.win_opt inside {WIN_STAY_IN, WIN_STAY_OUT}
    && s_q.win_cond == DUR_WITHIN
    && win_end && s_q.wcnt == s_q.win_w && !i_cfg_load
    |=> o_trigger)
    else $error("Nominal stay in within mode did not trigger");
  win_shorter_a: assert property (s_q.kind == KIND_WINDOW
    && s_q.win_opt != WIN_ENTER && s_q.win_opt != WIN_EXIT
    && s_q.win_cond == DUR_SHORTER && win_end
    && s_q.wcnt >= s_q.win_w |=> !o_trigger)
    else $error("Shorter mode fired on a long stay");
  win_longer_a: assert property (s_q.kind == KIND_WINDOW
    && s_q.win_opt inside {WIN_STAY_IN, WIN_STAY_OUT}
    && s_q.win_cond == DUR_LONGER
    && wq_now && s_q.wcnt == s_q.win_w && !i_cfg_load
    |=> o_trigger ##1 !o_trigger)
    else $error("Longer mode did not fire once");
  timeout_a: assert property (s_q.kind == KIND_TIMEOUT && to_cond
    && tcnt_n == s_q.to_dur && s_q.tcnt != s_q.to_dur && !i_cfg_load
    |=> o_trigger)
    else $error("Timeout did not trigger");
  gap_shorter_a: assert property (s_q.kind == KIND_INTERVAL
    && s_q.gap_cmp == GAP_SHORTER && gap_edge && s_q.armed
    && s_q.gcnt >= s_q.gap_w |=> !o_trigger)
    else $error("Shorter interval fired on a long gap");
  gap_longer_a: assert property (s_q.kind == KIND_INTERVAL
    && s_q.gap_cmp == GAP_LONGER && gap_edge && s_q.armed
    && s_q.gcnt > s_q.gap_w && !i_cfg_load |=> o_trigger)
    else $error("Longer interval did not trigger");
  gap_within_a: assert property (s_q.kind == KIND_INTERVAL
    && s_q.gap_cmp == GAP_WITHIN && gap_edge && s_q.armed
    && s_q.gcnt == s_q.gap_w && !i_cfg_load |=> o_trigger)
    else $error("Nominal interval in within mode did not trigger");
  unarmed_gap_a: assert property (s_q.kind == KIND_INTERVAL
    && !s_q.armed |=> !o_trigger)
    else $error("Interval fired before a first edge");
  no_cause_a: assert property (!fire |=> !o_trigger)
    else $error("Trigger without qualification");

  win_trig_c: cover property (s_q.kind == KIND_WINDOW ##1 o_trigger);
  to_trig_c:  cover property (s_q.kind == KIND_TIMEOUT ##1 o_trigger);
  gap_trig_c: cover property (s_q.kind == KIND_INTERVAL ##1 o_trigger);
endmodule

// ===== tb/comparator_front_model.sv
// Behavioural comparator front end that feeds the trigger block
`timescale 1ns/10ps
module comparator_front_model #(
  parameter int NCH = 8
) (
  input  wire                   i_clk,
  input  wire [$clog2(NCH)-1:0] i_chan,
  input  wire [1:0]             i_state,
  output logic [NCH-1:0]        o_above_upper,
  output logic [NCH-1:0]        o_below_lower,
  output logic [NCH-1:0]        o_above_level
);
  // States: 0 inside low, 1 above upper, 2 below lower, 3 inside high
  logic noise_q = 1'b0;

  // Unselected channels never settle, so a wrong channel shows up
  always @(posedge i_clk)
    noise_q <= #1 ~noise_q;

  always_comb
  begin
    o_above_upper = {NCH{noise_q}};
    o_below_lower = {NCH{~noise_q}};
    o_above_level = {NCH{noise_q}};
    o_above_upper[i_chan] = (i_state == 2'h1);
    o_below_lower[i_chan] = (i_state == 2'h2);
    o_above_level[i_chan] = i_state[0];
  end
endmodule

// ===== tb/window_timeout_interval_trigger_test.sv
// Self-checking bench of the time-qualified trigger
`timescale 1ns/10ps
`include "trig_defs.svh"
module window_timeout_interval_trigger_test;
  import trig_pkg::*;
  localparam int CW = `CNT_WIDTH;
  localparam int NCH = `CHAN_COUNT;
  // Kind, option, mode, polarity, channel, width, tolerance, states, runs
  typedef struct {
    logic [1:0] k, o, m, p;
    logic [2:0] ch;
    logic [7:0] w, t;
    logic [1:0] idle, act;
    int         a, b, c, n;
  } row_t;
  logic          i_clk = 1'b0;
  logic          i_rst_n = 1'b0;
  logic          i_cfg_load = 1'b0;
  logic [2:0]    i_src_chan = 3'h0;
  logic [1:0]    st = 2'h1;
  trig_kind_t    kind = KIND_WINDOW;
  win_option_t   wopt = WIN_ENTER;
  dur_cond_t     wcond = DUR_WITHIN;
  stuck_pol_t    spol = STUCK_HIGH;
  gap_cmp_t      gcmp = GAP_OUTSIDE;
  gap_pol_t      gpol = EDGE_RISE;
  logic [CW-1:0] wid = '0;
  logic [CW-1:0] tol = '0;
  logic [NCH-1:0] up, lo, lv;
  logic          o_trigger, o_gap_armed;
  int            n_errors = 0;
  int            total_checks = 0;
  int            trig_cnt = 0;
  row_t          rr;
  row_t rows [22] = '{
    '{KIND_WINDOW,WIN_ENTER,DUR_SHORTER,0,0,200,0,1,0,4,6,4,2},
    '{KIND_WINDOW,WIN_EXIT,DUR_LONGER,0,5,1,0,1,0,4,6,4,2},
    '{KIND_WINDOW,WIN_STAY_IN,DUR_WITHIN,0,3,10,2,1,0,8,6,13,1},
    '{KIND_WINDOW,WIN_STAY_IN,DUR_WITHIN,0,3,10,2,1,0,7,6,12,1},
    '{KIND_WINDOW,WIN_STAY_IN,DUR_OUTSIDE,0,1,10,2,1,0,7,6,13,2},
    '{KIND_WINDOW,WIN_STAY_IN,DUR_OUTSIDE,0,1,10,2,1,0,8,6,12,0},
    '{KIND_WINDOW,WIN_STAY_IN,DUR_SHORTER,0,4,10,0,1,0,9,6,10,1},
    '{KIND_WINDOW,WIN_STAY_IN,DUR_LONGER,0,6,10,0,1,0,10,6,11,1},
    '{KIND_WINDOW,WIN_STAY_OUT,DUR_WITHIN,0,2,5,0,0,2,5,6,6,1},
    '{KIND_WINDOW,WIN_STAY_OUT,DUR_SHORTER,0,7,5,0,0,1,4,6,5,1},
    '{KIND_TIMEOUT,0,0,STUCK_HIGH,2,6,0,0,3,5,4,9,1},
    '{KIND_TIMEOUT,0,0,STUCK_LOW,7,6,0,3,0,6,4,20,2},
    '{KIND_TIMEOUT,0,0,STUCK_ANY_POLARITY,0,12,0,0,3,11,12,3,2},
    '{KIND_TIMEOUT,0,0,STUCK_HIGH,0,0,0,0,3,5,4,9,0},
    '{KIND_INTERVAL,0,GAP_OUTSIDE,EDGE_RISE,1,10,1,0,3,4,4,2,1},
    '{KIND_INTERVAL,0,GAP_OUTSIDE,EDGE_RISE,1,10,1,0,3,4,5,2,0},
    '{KIND_INTERVAL,0,GAP_WITHIN,EDGE_RISE,3,10,1,0,3,4,7,2,1},
    '{KIND_INTERVAL,0,GAP_WITHIN,EDGE_FALL,3,10,1,0,3,2,5,5,1},
    '{KIND_INTERVAL,0,GAP_SHORTER,EDGE_RISE,5,10,0,0,3,4,5,2,1},
    '{KIND_INTERVAL,0,GAP_LONGER,EDGE_RISE,6,10,0,0,3,4,6,2,0},
    '{KIND_INTERVAL,0,GAP_LONGER,EDGE_RISE,6,10,0,0,3,5,6,2,1},
    '{KIND_INTERVAL,0,GAP_SHORTER,EDGE_ANY_POLARITY,4,4,0,0,3,3,5,2,2}
  };

  always #10 i_clk = ~i_clk;

  always @(posedge i_clk)
    if (o_trigger === 1'b1)
      trig_cnt <= trig_cnt + 1;

  comparator_front_model #(.NCH(NCH)) model (
    .i_clk(i_clk), .i_chan(i_src_chan), .i_state(st),
    .o_above_upper(up), .o_below_lower(lo), .o_above_level(lv)
  );

  time_qual_trigger DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_above_upper(up),
    .i_below_lower(lo), .i_above_level(lv), .i_cfg_load(i_cfg_load),
    .i_src_chan(i_src_chan), .i_trig_kind(kind),
    .i_window_compare_option(wopt), .i_window_duration_condition(wcond),
    .i_window_nominal_duration(wid), .i_window_duration_tolerance(tol),
    .i_stuck_level_polarity(spol), .i_stuck_level_duration(wid),
    .i_edge_gap_compare_option(gcmp), .i_edge_gap_polarity(gpol),
    .i_edge_gap_nominal(wid), .i_edge_gap_tolerance(tol),
    .o_trigger(o_trigger), .o_gap_armed(o_gap_armed)
  );

  task automatic check_bit(input string name, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic check_cnt(input string name, input int e, input int g);
    total_checks++;
    if (g != e)
    begin
      n_errors++;
      $display("Error %s expected %0d seen %0d", name, e, g);
    end
  endtask

  task automatic summarize();
    $display("Checks made %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Drive a comparator state for n cycles, just after each edge
  task automatic hold(input logic [1:0] s, input int n);
    st = s;
    repeat (n) @(posedge i_clk) #1;
  endtask

  // Old setting sees noise until loaded; count starts once it is gone
  task automatic setup(input row_t r, output int base);
    i_src_chan = r.ch;
    kind = trig_kind_t'(r.k);
    wopt = win_option_t'(r.o);
    wcond = dur_cond_t'(r.m);
    gcmp = gap_cmp_t'(r.m);
    spol = stuck_pol_t'(r.p);
    gpol = gap_pol_t'(r.p);
    wid = CW'(r.w);
    tol = CW'(r.t);
    hold(r.idle, 4);
    i_cfg_load = 1'b1;
    hold(r.idle, 1);
    i_cfg_load = 1'b0;
    hold(r.idle, 7);
    base = trig_cnt;
  endtask

  task automatic play(input row_t r);
    int base;
    setup(r, base);
    if (r.k == KIND_INTERVAL)
      check_bit("gap_armed", 1'b0, o_gap_armed);
    hold(r.act, r.a);
    hold(r.idle, r.b);
    hold(r.act, r.c);
    hold(r.idle, 20);
    check_cnt("triggers", r.n, trig_cnt - base);
    if (r.k == KIND_INTERVAL)
      check_bit("gap_armed", 1'b1, o_gap_armed);
  endtask

  initial
  begin
    int base;
    hold(2'h1, 8);
    check_bit("trigger", 1'b0, o_trigger);
    check_bit("gap_armed", 1'b0, o_gap_armed);
    i_rst_n = 1'b1;
    hold(2'h1, 4);
    hold(2'h0, 2);
    check_bit("trigger", 1'b0, o_trigger);
    hold(2'h0, 1);
    check_bit("trigger", 1'b1, o_trigger);
    hold(2'h0, 1);
    check_bit("trigger", 1'b0, o_trigger);
    foreach (rows[i])
      play(rows[i]);
    // Reset in mid-run must drop the partial timeout run
    rr = '{KIND_TIMEOUT,0,0,STUCK_HIGH,0,10,0,0,3,0,0,0,0};
    setup(rr, base);
    hold(2'h3, 8);
    i_rst_n = 1'b0;
    hold(2'h3, 2);
    check_bit("trigger", 1'b0, o_trigger);
    check_bit("gap_armed", 1'b0, o_gap_armed);
    i_rst_n = 1'b1;
    i_cfg_load = 1'b1;
    hold(2'h3, 1);
    i_cfg_load = 1'b0;
    hold(2'h3, 6);
    hold(2'h0, 6);
    check_cnt("triggers", 0, trig_cnt - base);
    summarize();
  end
endmodule
